//--- rtl/ldr_data_regs.sv
// file: logic unit data registers: scratch, input interface, write buffer
// Notes on behaviour
// RL1 - three 16-bit scratch regs, any mix loaded at once from shift matrix
// RL2 - nanocode picks one scratch register as the adder primary operand
// RL3 - input interface register captures words from memory and device ports
// RL4 - input interface register feeds only the adder secondary operand
// RL5 - input interface register can also hold selected adder results
// RL6 - nanocode acts separately on lsb, msb and 14 middle bits
// RL7 - 16-bit write buffer loads only from the shift matrix output
// RL8 - write buffer drives memory data, port data and input register load
// RL9 - all transfers are timed by one processor clock at 1 MHz
// RL10 - adder result goes to shift matrix; to input register on request only
// RL11 - shift matrix output loads scratch, input and write buffer registers; here it loads only scratch and write buffer
// RL12 - a register holds its value whenever its load select is low
`timescale 1ns/100ps
module ldr_data_regs (
    input wire logic clk,
    input wire logic reset,
    input wire ldr_pkg::ldr_nano_t nano,
    input wire ldr_pkg::ldr_word_t shift_matrix_out,
    input wire ldr_pkg::ldr_word_t adder_result,
    input wire ldr_pkg::ldr_word_t data_program_memory_data,
    input wire ldr_pkg::ldr_word_t device_port_data,
    output ldr_pkg::ldr_word_t adder_primary,
    output ldr_pkg::ldr_word_t adder_secondary,
    output ldr_pkg::ldr_word_t shift_matrix_in,
    output ldr_pkg::ldr_word_t memory_write_data,
    output ldr_pkg::ldr_word_t device_port_write_data,
    output logic proc_tick
);
    ldr_pkg::ldr_word_t scratch_q [ldr_pkg::NUM_SCRATCH];
    ldr_pkg::ldr_word_t in_reg_q;
    ldr_pkg::ldr_word_t in_reg_d;
    ldr_pkg::ldr_word_t write_buffer_q;
    ldr_pkg::ldr_word_t primary_d;
    logic tick;

    // one system clock; processor-rate transfers use this enable
    ldr_rate_div u_div (
        .clk(clk),
        .reset(reset),
        .tick(tick)
    ); // see RL9
    assign proc_tick = tick;

    function automatic logic apply_bit(input ldr_pkg::ldr_fld_op_t op,
                                       input logic b);
        case (op)
            ldr_pkg::LDR_FLD_PASS: apply_bit = b;
            ldr_pkg::LDR_FLD_ZERO: apply_bit = 1'b0;
            ldr_pkg::LDR_FLD_ONE: apply_bit = 1'b1;
            ldr_pkg::LDR_FLD_INVERT: apply_bit = ~b;
            default: apply_bit = b;
        endcase
    endfunction

    // scratch registers load in any combination from the shift matrix
    genvar i;
    for (i = 0; i < ldr_pkg::NUM_SCRATCH; i++) begin : g_scratch
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                scratch_q[i] <= ldr_pkg::WORD_RESET;
            end else if (tick && nano.scratch_load[i]) begin
                scratch_q[i] <= shift_matrix_out; // see RL1 see RL11
            end // see RL12
        end
    end

    // out-of-range primary select gives zero rather than a stale register
    always_comb begin
        primary_d = ldr_pkg::WORD_RESET;
        if (nano.primary_sel < 2'(ldr_pkg::NUM_SCRATCH)) begin
            primary_d = scratch_q[nano.primary_sel]; // see RL2
        end
    end
    assign adder_primary = primary_d;

    // adder result request outranks the other sources
    always_comb begin
        in_reg_d = in_reg_q; // see RL12
        if (nano.in_from_adder) begin
            in_reg_d = adder_result; // see RL5 see RL10
        end else begin
            case (nano.in_sel)
                ldr_pkg::LDR_IN_MEMORY: in_reg_d = data_program_memory_data;
                ldr_pkg::LDR_IN_PORT: in_reg_d = device_port_data; // see RL3
                ldr_pkg::LDR_IN_BUFFER: in_reg_d = write_buffer_q; // see RL8
                default: in_reg_d = in_reg_q;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            in_reg_q <= ldr_pkg::WORD_RESET;
        end else if (tick) begin
            in_reg_q <= in_reg_d;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            write_buffer_q <= ldr_pkg::WORD_RESET;
        end else if (tick && nano.buffer_load) begin
            write_buffer_q <= shift_matrix_out; // see RL7 see RL11
        end
    end

    // input register reaches nothing but the secondary operand; each bit
    // takes the op of its own field so lsb, msb and middle stay apart
    genvar j;
    for (j = 0; j < ldr_pkg::WORD_W; j++) begin : g_field // see RL4
        if (j == ldr_pkg::LSB_POS) begin : g_lsb // see RL6
            assign adder_secondary[j] = apply_bit(nano.lsb_op, in_reg_q[j]);
        end else if (j == ldr_pkg::MSB_POS) begin : g_msb
            assign adder_secondary[j] = apply_bit(nano.msb_op, in_reg_q[j]);
        end else begin : g_mid
            assign adder_secondary[j] = apply_bit(nano.mid_op, in_reg_q[j]);
        end
    end

    assign shift_matrix_in = adder_result; // see RL10
    assign memory_write_data = write_buffer_q; // see RL8
    assign device_port_write_data = write_buffer_q;

    scratch_hold_a: assert property (@(posedge clk) disable iff (reset)
        !(tick && nano.scratch_load[0]) |=> $stable(scratch_q[0]))
        else $error("scratch one changed without load"); // see RL12
    scratch_two_hold_a: assert property (@(posedge clk) disable iff (reset)
        !(tick && nano.scratch_load[1]) |=> $stable(scratch_q[1]))
        else $error("scratch two changed without load"); // see RL12
    scratch_three_hold_a: assert property (@(posedge clk) disable iff (reset)
        !(tick && nano.scratch_load[2]) |=> $stable(scratch_q[2]))
        else $error("scratch three changed without load"); // see RL12
    scratch_one_load_a: assert property (@(posedge clk) disable iff (reset)
        tick && nano.scratch_load[0]
        |=> scratch_q[0] == $past(shift_matrix_out))
        else $error("scratch one missed load"); // see RL11
    scratch_two_load_a: assert property (@(posedge clk) disable iff (reset)
        tick && nano.scratch_load[1]
        |=> scratch_q[1] == $past(shift_matrix_out))
        else $error("scratch two missed load"); // see RL1
    scratch_load_a: assert property (@(posedge clk) disable iff (reset)
        tick && nano.scratch_load[2]
        |=> scratch_q[2] == $past(shift_matrix_out))
        else $error("scratch three missed load"); // see RL1

    primary_first_a: assert property (@(posedge clk) disable iff (reset)
        nano.primary_sel == 2'h0 |-> adder_primary == scratch_q[0])
        else $error("primary operand not scratch one"); // see RL2
    primary_sel_a: assert property (@(posedge clk) disable iff (reset)
        nano.primary_sel == 2'h1 |-> adder_primary == scratch_q[1])
        else $error("primary operand wrong"); // see RL2
    primary_third_a: assert property (@(posedge clk) disable iff (reset)
        nano.primary_sel == 2'h2 |-> adder_primary == scratch_q[2])
        else $error("primary operand not scratch three"); // see RL2
    primary_zero_a: assert property (@(posedge clk) disable iff (reset)
        nano.primary_sel == 2'h3 |-> adder_primary == ldr_pkg::WORD_RESET)
        else $error("unused primary select not zero"); // see RL2

    buffer_load_a: assert property (@(posedge clk) disable iff (reset)
        tick && nano.buffer_load
        |=> memory_write_data == $past(shift_matrix_out))
        else $error("write buffer missed load"); // see RL7
    buffer_hold_a: assert property (@(posedge clk) disable iff (reset)
        !(tick && nano.buffer_load) |=> $stable(write_buffer_q))
        else $error("write buffer changed without load"); // see RL12
    memory_capture_a: assert property (@(posedge clk) disable iff (reset)
        tick && !nano.in_from_adder && nano.in_sel == ldr_pkg::LDR_IN_MEMORY
        |=> in_reg_q == $past(data_program_memory_data))
        else $error("memory word not captured"); // see RL3
    in_idle_hold_a: assert property (@(posedge clk) disable iff (reset)
        tick && !nano.in_from_adder && nano.in_sel == ldr_pkg::LDR_IN_NONE
        |=> $stable(in_reg_q))
        else $error("input register changed without load"); // see RL10
    adder_capture_a: assert property (@(posedge clk) disable iff (reset)
        tick && nano.in_from_adder |=> in_reg_q == $past(adder_result))
        else $error("adder result not captured"); // see RL5
    port_capture_a: assert property (@(posedge clk) disable iff (reset)
        tick && !nano.in_from_adder && nano.in_sel == ldr_pkg::LDR_IN_PORT
        |=> in_reg_q == $past(device_port_data))
        else $error("port word not captured"); // see RL3
    buffer_route_a: assert property (@(posedge clk) disable iff (reset)
        tick && !nano.in_from_adder && nano.in_sel == ldr_pkg::LDR_IN_BUFFER
        |=> in_reg_q == $past(device_port_write_data))
        else $error("buffer not routed to input register"); // see RL8
    in_hold_a: assert property (@(posedge clk) disable iff (reset)
        !tick |=> $stable(in_reg_q))
        else $error("input register moved off tick"); // see RL9
    field_ops_a: assert property (@(posedge clk) disable iff (reset)
        nano.msb_op == ldr_pkg::LDR_FLD_INVERT && nano.lsb_op ==
        ldr_pkg::LDR_FLD_ZERO && nano.mid_op == ldr_pkg::LDR_FLD_PASS
        |-> adder_secondary == {~in_reg_q[15], in_reg_q[14:1], 1'b0})
        else $error("field manipulation wrong"); // see RL6
    tick_period_a: assert property (@(posedge clk) disable iff (reset)
        tick |=> !tick [*8])
        else $error("processor tick too frequent"); // see RL9
    tick_rate_a: assert property (@(posedge clk) disable iff (reset)
        tick |-> ##50 tick)
        else $error("processor tick period wrong"); // see RL9

    pass_fields_a: assert property (@(posedge clk) disable iff (reset)
        nano.lsb_op == ldr_pkg::LDR_FLD_PASS
        && nano.msb_op == ldr_pkg::LDR_FLD_PASS
        && nano.mid_op == ldr_pkg::LDR_FLD_PASS
        |-> adder_secondary == in_reg_q)
        else $error("secondary operand not the input register"); // see RL4
    lsb_one_a: assert property (@(posedge clk) disable iff (reset)
        nano.lsb_op == ldr_pkg::LDR_FLD_ONE |-> adder_secondary[0] == 1'h1)
        else $error("lsb not forced to one"); // see RL6
    lsb_invert_a: assert property (@(posedge clk) disable iff (reset)
        nano.lsb_op == ldr_pkg::LDR_FLD_INVERT
        |-> adder_secondary[0] == ~in_reg_q[0])
        else $error("lsb not inverted"); // see RL6
    msb_one_a: assert property (@(posedge clk) disable iff (reset)
        nano.msb_op == ldr_pkg::LDR_FLD_ONE |-> adder_secondary[15] == 1'h1)
        else $error("msb not forced to one"); // see RL6
    msb_zero_a: assert property (@(posedge clk) disable iff (reset)
        nano.msb_op == ldr_pkg::LDR_FLD_ZERO |-> adder_secondary[15] == 1'h0)
        else $error("msb not forced to zero"); // see RL6
    mid_zero_a: assert property (@(posedge clk) disable iff (reset)
        nano.mid_op == ldr_pkg::LDR_FLD_ZERO
        |-> adder_secondary[14:1] == 14'h0000)
        else $error("middle bits not forced to zero"); // see RL6
    mid_invert_a: assert property (@(posedge clk) disable iff (reset)
        nano.mid_op == ldr_pkg::LDR_FLD_INVERT
        |-> adder_secondary[14:1] == ~in_reg_q[14:1])
        else $error("middle bits not inverted"); // see RL6
endmodule

//--- rtl/ldr_pkg.sv
// package: widths, positions and carrier types of the data registers
package ldr_pkg;
    localparam int WORD_W = 16;
    localparam int MSB_POS = 15;
    localparam int LSB_POS = 0;
    localparam int MID_W = 14;
    localparam int NUM_SCRATCH = 3;
    localparam int CLK_MHZ = 50;
    // documented processor rate; transfers are paced by an enable at this rate
    localparam int PROC_MHZ = 1;
    localparam int PROC_DIV = CLK_MHZ / PROC_MHZ;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    typedef logic [WORD_W-1:0] ldr_word_t;

    // source choice for the input interface register
    typedef enum logic [1:0] {
        LDR_IN_NONE,
        LDR_IN_MEMORY,
        LDR_IN_PORT,
        LDR_IN_BUFFER
    } ldr_in_sel_t;

    // treatment of one field of the secondary operand
    typedef enum logic [1:0] {
        LDR_FLD_PASS,
        LDR_FLD_ZERO,
        LDR_FLD_ONE,
        LDR_FLD_INVERT
    } ldr_fld_op_t;

    typedef struct packed {
        logic [NUM_SCRATCH-1:0] scratch_load;
        logic [1:0] primary_sel;
        ldr_in_sel_t in_sel;
        logic in_from_adder;
        logic buffer_load;
        ldr_fld_op_t lsb_op;
        ldr_fld_op_t msb_op;
        ldr_fld_op_t mid_op;
    } ldr_nano_t;
endpackage

//--- rtl/ldr_rate_div.sv
// file: divider giving a one-cycle enable at the processor rate
`timescale 1ns/100ps
module ldr_rate_div (
    input wire logic clk,
    input wire logic reset,
    output logic tick
);
    logic [5:0] count_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_q <= 6'h00;
        end else if (count_q == 6'(ldr_pkg::PROC_DIV - 1)) begin
            count_q <= 6'h00;
        end else begin
            count_q <= count_q + 6'h01;
        end
    end

    assign tick = (count_q == 6'(ldr_pkg::PROC_DIV - 1));
endmodule

//--- testbench/ldr_far_model.sv
// far side model: adder summing both operands of the data registers
`timescale 1ns/100ps
module ldr_far_model (
    input wire ldr_pkg::ldr_word_t primary,
    input wire ldr_pkg::ldr_word_t secondary,
    output ldr_pkg::ldr_word_t sum
);
    // carry out dropped, only the 16-bit result reaches the registers
    assign sum = 16'(primary + secondary);
endmodule

//--- testbench/testbench.sv
// self-checking bench of the logic unit data registers
`timescale 1ns/100ps
module testbench;
    logic clk, reset, tick;
    ldr_pkg::ldr_nano_t nano, n;
    ldr_pkg::ldr_word_t sm, mem, prt, pri, sec, smi, mwd, pwd, sum;
    int failures, checks, gap;
    ldr_data_regs dut (.clk(clk), .reset(reset), .nano(nano),
        .shift_matrix_out(sm), .adder_result(sum),
        .data_program_memory_data(mem), .device_port_data(prt),
        .adder_primary(pri), .adder_secondary(sec), .shift_matrix_in(smi),
        .memory_write_data(mwd), .device_port_write_data(pwd),
        .proc_tick(tick));
    ldr_far_model far (.primary(pri), .secondary(sec), .sum(sum));
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    task check(string what, ldr_pkg::ldr_word_t seen, ldr_pkg::ldr_word_t exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task complete_run;
        $display("failures %0d checks %0d", failures, checks);
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // a tick that never comes is counted, so the run cannot stall here
    task wait_tick;
        gap = 0;
        do begin
            @(negedge clk);
            gap++;
        end while (tick !== 1'b1 && gap < 60);
        check("tick seen", 16'(tick), 16'h0001);
    endtask
    // controls held across the wait so the tick edge surely samples them
    task tick_load(ldr_pkg::ldr_nano_t c, ldr_pkg::ldr_word_t w);
        @(posedge clk) nano <= c;
        sm <= w;
        wait_tick;
        c.scratch_load = '0;
        c.buffer_load = 1'h0;
        c.in_from_adder = 1'h0;
        c.in_sel = ldr_pkg::LDR_IN_NONE;
        @(posedge clk) nano <= c;
        #1;
    endtask
    task sel(logic [1:0] s);
        @(posedge clk) nano.primary_sel <= s;
        #1;
    endtask
    task t_scratch;
        for (int i = 0; i < 3; i++) begin
            n = '0;
            n.scratch_load = 3'h1 << i;
            tick_load(n, 16'(16'h1111 * (i + 1)));
        end
        for (int i = 0; i < 3; i++) begin
            sel(i[1:0]);
            check("scratch", pri, 16'(16'h1111 * (i + 1)));
        end
        sel(2'h3);
        check("primary none", pri, 16'h0000);
        n = '0;
        n.scratch_load = 3'h7;
        tick_load(n, 16'hA5C3);
        for (int i = 0; i < 3; i++) begin
            sel(i[1:0]);
            check("scratch all", pri, 16'hA5C3);
        end
        n = '0;
        tick_load(n, 16'hFFFF);
        check("scratch hold", pri, 16'hA5C3);
        // loads raised well clear of a tick must not reach the registers
        n.scratch_load = 3'h7;
        @(posedge clk) nano <= n;
        sm <= 16'h0F0F;
        repeat (3) @(posedge clk);
        #1 check("off tick", pri, 16'hA5C3);
        @(posedge clk) nano <= '0;
    endtask
    task t_buffer;
        n = '0;
        n.buffer_load = 1;
        tick_load(n, 16'h3C5A);
        check("mem write", mwd, 16'h3C5A);
        check("port write", pwd, 16'h3C5A);
        n = '0;
        n.in_sel = ldr_pkg::LDR_IN_BUFFER;
        tick_load(n, 16'h0000);
        check("from buffer", sec, 16'h3C5A);
        check("buffer hold", mwd, 16'h3C5A);
    endtask
    task t_inputs;
        ldr_pkg::ldr_word_t m, e;
        @(posedge clk) mem <= 16'h8001;
        prt <= 16'h7FFE;
        n = '0;
        n.in_sel = ldr_pkg::LDR_IN_MEMORY;
        tick_load(n, 16'h0000);
        check("from memory", sec, 16'h8001);
        n.in_sel = ldr_pkg::LDR_IN_PORT;
        tick_load(n, 16'h0000);
        check("from port", sec, 16'h7FFE);
        n = '0;
        tick_load(n, 16'h0000);
        check("input hold", sec, 16'h7FFE);
        for (int f = 0; f < 3; f++) begin
            for (int o = 0; o < 4; o++) begin
                n = '0;
                m = f == 0 ? 16'h0001 : f == 1 ? 16'h8000 : 16'h7FFE;
                if (f == 0) n.lsb_op = ldr_pkg::ldr_fld_op_t'(o);
                else if (f == 1) n.msb_op = ldr_pkg::ldr_fld_op_t'(o);
                else n.mid_op = ldr_pkg::ldr_fld_op_t'(o);
                e = o == 0 ? 16'h7FFE : o == 1 ? 16'h7FFE & ~m :
                    o == 2 ? 16'h7FFE | m : 16'h7FFE ^ m;
                @(posedge clk) nano <= n;
                #1 check("field op", sec, e);
            end
        end
        n = '0;
        n.msb_op = ldr_pkg::LDR_FLD_INVERT;
        n.lsb_op = ldr_pkg::LDR_FLD_ZERO;
        @(posedge clk) nano <= n;
        #1 check("field mix", sec, 16'hFFFE);
    endtask
    task t_adder;
        @(posedge clk) nano <= '0;
        #1 check("to shifter", smi, 16'h25C1);
        n = '0;
        n.in_from_adder = 1;
        n.in_sel = ldr_pkg::LDR_IN_MEMORY;
        tick_load(n, 16'h0000);
        check("adder result", sec, 16'h25C1);
    endtask
    task t_period;
        wait_tick;
        wait_tick;
        check("tick spacing", 16'(gap), 16'(ldr_pkg::PROC_DIV));
    endtask
    initial begin
        failures = 0;
        checks = 0;
        reset = 1;
        nano = '0;
        sm = '0;
        mem = '0;
        prt = '0;
        repeat (10) @(posedge clk);
        reset <= 0;
        #1 check("reset primary", pri, 16'h0000);
        check("reset buffer", mwd, 16'h0000);
        t_scratch;
        t_buffer;
        t_inputs;
        t_adder;
        t_period;
        complete_run;
    end
    initial begin
        #400000;
        failures++;
        complete_run;
    end
endmodule
